// ==== ebt_bus_timing.sv ====
// External bus cycle sequencer with clock divider, serial rate and POR delay
`timescale 1ns/1ps
module ebt_bus_timing #(
   parameter int POR_COUNT = ebt_pkg::POR_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input ebt_pkg::ebt_cfg_t cfg,
   input wire logic fetch_req,
   input wire logic page_hit,
   input wire logic data_req,
   input wire logic data_write,
   output logic sys_clk_en,
   output logic reserved_div,
   output logic por_active,
   output logic bus_busy,
   output logic cycle_done,
   output logic [3:0] external_data_move_cycles,
   output logic addr_latch_strobe,
   output logic program_fetch_strobe_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic serial_clk
);
   import ebt_pkg::*;

   if (POR_COUNT < 2 || POR_COUNT > 65536) begin : g_bad_por
      $error("POR_COUNT out of range");
   end

   // ---------------------------------------------------------------
   // Reset release and power-on delay
   // ---------------------------------------------------------------
   logic rst_s1_q;
   logic rst_n_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // Counts core clocks, four per oscillator clock, once the clock runs cleanly
   logic [16:0] por_cnt_q;
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         por_cnt_q <= 17'h0;
      end else if (por_cnt_q != 17'(POR_COUNT)) begin
         por_cnt_q <= por_cnt_q + 17'h1;
      end
   end
   assign por_active = (por_cnt_q != 17'(POR_COUNT));

   // ---------------------------------------------------------------
   // System clock enable from multiplier and divider
   // ---------------------------------------------------------------
   // Core clock stands for the multiplied clock; each enable is one tick.
   // The caller keeps the oscillator in range for the multiplier.
   logic [1:0] div_sel;
   logic [9:0] div_cnt_q;
   logic [9:0] div_last;
   assign div_sel = {cfg.clock_divider_sel_hi, cfg.clock_divider_sel_lo};
   always_comb begin
      case (div_sel)
         DIV_BY_MULT: div_last = cfg.clock_multiplier_select ? 10'h0 : 10'h1;
         DIV_ONE: div_last = 10'h3;
         DIV_1024: div_last = 10'(4 * SLOW_DIV - 1 > 1023 ? 1023 : 0);
         default: div_last = 10'h0;
      endcase
   end
   assign reserved_div = (div_sel == DIV_RSVD);
   // 1024 divide needs 4096 ticks; two extra bits extend the counter
   logic [1:0] div_hi_q;
   logic div_hit;
   // At or past the end point, so a divider change or the POR wait never waits for a wrap
   assign div_hit = (div_cnt_q >= div_last) && ((div_sel != DIV_1024) || (div_hi_q == 2'h3));
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         div_cnt_q <= 10'h0;
         div_hi_q <= 2'h0;
      end else if (div_hit) begin
         div_cnt_q <= 10'h0;
         div_hi_q <= 2'h0;
      end else begin
         div_cnt_q <= div_cnt_q + 10'h1;
         if (div_cnt_q == 10'h3FF) begin
            div_hi_q <= div_hi_q + 2'h1;
         end
      end
   end
   assign sys_clk_en = !por_active && div_hit;

   // ---------------------------------------------------------------
   // Stretch decode
   // ---------------------------------------------------------------
   ebt_cfg_t cfg_q;
   ebt_ext_t ext;
   ebt_stretch_decode u_dec (
      .code(cfg_q.stretch_code),
      .ext(ext)
   );
   // Live decode for the latch phase, loaded at the edge that samples cfg_q
   ebt_ext_t ext_new;
   ebt_stretch_decode u_dec_new (.code(cfg.stretch_code), .ext(ext_new));
   assign external_data_move_cycles = 4'(EXTERNAL_DATA_MOVE_BASE_CYC) + {1'b0, cfg_q.stretch_code};

   // ---------------------------------------------------------------
   // Bus sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LATCH = 3'b001,
      ST_SETUP = 3'b010,
      ST_STROBE = 3'b011,
      ST_RECOVER = 3'b100,
      ST_FETCH = 3'b101
   } ebt_state_t;
   ebt_state_t state_q;
   logic [4:0] cnt_q;
   logic is_data_q;
   logic is_write_q;
   logic hold_fetch_q;
   logic one_clk_strobe;
   assign one_clk_strobe = (cfg_q.page == PG_ONE_CYC) || (cfg_q.page == PG_TWO_CYC);

   // Latch width per mode; default mode gives two ticks of four
   function automatic logic [4:0] latch_len(input ebt_page_t pg);
      case (pg)
         PG_ONE_CYC: latch_len = 5'h1;
         PG_TWO_CYC: latch_len = 5'h1;
         PG_FOUR_CYC: latch_len = 5'h2;
         default: latch_len = DEF_LATCH_HI;
      endcase
   endfunction

   // Configuration sampled on every idle sys tick, never mid-cycle
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cfg_q <= '0;
      end else if (sys_clk_en && state_q == ST_IDLE) begin
         cfg_q <= cfg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_IDLE;
         cnt_q <= 5'h0;
         is_data_q <= 1'b0;
         is_write_q <= 1'b0;
         hold_fetch_q <= 1'b0;
      end else if (sys_clk_en) begin
         case (state_q)
            ST_IDLE: begin
               if (data_req) begin
                  is_data_q <= 1'b1;
                  is_write_q <= data_write;
                  hold_fetch_q <= 1'b0;
                  state_q <= ST_LATCH;
                  cnt_q <= latch_len(cfg.page) + ext_new.latch_pulse_extension - 5'h1;
               end else if (fetch_req) begin
                  is_data_q <= 1'b0;
                  // Page hit in one-cycle mode skips the latch phase
                  if (hold_fetch_q && page_hit && cfg.page == PG_ONE_CYC) begin
                     state_q <= ST_FETCH;
                     cnt_q <= 5'h0;
                  end else begin
                     state_q <= ST_LATCH;
                     cnt_q <= latch_len(cfg.page) - 5'h1;
                  end
               end else begin
                  hold_fetch_q <= 1'b0;
               end
            end
            ST_LATCH: begin
               if (cnt_q == 5'h0) begin
                  state_q <= is_data_q ? ST_SETUP : ST_FETCH;
                  cnt_q <= is_data_q ? ext.setup_recovery_extension + ext.address_valid_extension
                           : ((cfg_q.page == PG_FOUR_CYC || cfg_q.page == PG_NONPAGE)
                              ? 5'h1 : 5'h0);
               end else begin
                  cnt_q <= cnt_q - 5'h1;
               end
            end
            ST_SETUP: begin
               if (cnt_q == 5'h0) begin
                  state_q <= ST_STROBE;
                  // Strobe low time one or two clocks plus extension
                  cnt_q <= ext.strobe_extension + (one_clk_strobe ? 5'h0 : 5'h1);
               end else begin
                  cnt_q <= cnt_q - 5'h1;
               end
            end
            ST_STROBE: begin
               if (cnt_q == 5'h0) begin
                  state_q <= ST_RECOVER;
                  cnt_q <= ext.setup_recovery_extension + ext.address_hold_extension;
               end else begin
                  cnt_q <= cnt_q - 5'h1;
               end
            end
            ST_RECOVER: begin
               // Latch may not rise until recovery has elapsed
               if (cnt_q == 5'h0) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 5'h1;
               end
            end
            ST_FETCH: begin
               if (cnt_q == 5'h0) begin
                  state_q <= ST_IDLE;
                  hold_fetch_q <= (cfg_q.page == PG_ONE_CYC);
               end else begin
                  cnt_q <= cnt_q - 5'h1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin strobes from state
   // ---------------------------------------------------------------
   always_comb begin
      addr_latch_strobe = (state_q == ST_LATCH);
      read_strobe_n = !(state_q == ST_STROBE && !is_write_q);
      write_strobe_n = !(state_q == ST_STROBE && is_write_q);
      // Fetch strobe stays low between page hits in one-cycle mode
      program_fetch_strobe_n = !((state_q == ST_FETCH) ||
                                 (state_q == ST_IDLE && hold_fetch_q));
      bus_busy = (state_q != ST_IDLE);
      cycle_done = sys_clk_en && cnt_q == 5'h0 &&
                   (state_q == ST_RECOVER || state_q == ST_FETCH);
   end

   // ---------------------------------------------------------------
   // Serial mode 0 shift clock
   // ---------------------------------------------------------------
   logic [3:0] ser_cnt_q;
   logic ser_mode0;
   logic [3:0] ser_half;
   assign ser_mode0 = !cfg.serial_mode_bit_a && !cfg.serial_mode_bit_b;
   assign ser_half = cfg.serial_clock_rate_bit ? 4'(SER_FAST / 2) : 4'(SER_SLOW / 2);
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ser_cnt_q <= 4'h0;
         serial_clk <= 1'b1;
      end else if (!ser_mode0) begin
         ser_cnt_q <= 4'h0;
         serial_clk <= 1'b1;
      end else if (sys_clk_en) begin
         if (ser_cnt_q >= ser_half - 4'h1) begin
            ser_cnt_q <= 4'h0;
            serial_clk <= !serial_clk;
         end else begin
            ser_cnt_q <= ser_cnt_q + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_LATCH_AFTER_STROBE: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      ($rose(read_strobe_n) || $rose(write_strobe_n)) |-> (!addr_latch_strobe &&
      state_q == ST_RECOVER && cnt_q >= ext.setup_recovery_extension))
      else $error("latch rose with strobe");
   AST_POR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      por_active |-> !sys_clk_en && !bus_busy)
      else $error("activity during power-on delay");
   AST_NO_BOTH_STROBES: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      !(!read_strobe_n && !write_strobe_n))
      else $error("read and write strobes together");
   AST_EXTERNAL_DATA_MOVE_LEN: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      external_data_move_cycles == 4'(cfg_q.stretch_code) + 4'h2)
      else $error("external_data_move length wrong");
   AST_STRETCH_EXT: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      cfg_q.stretch_code == 3'h7 |-> ext.strobe_extension == 5'd26)
      else $error("strobe extension wrong");
   AST_CODE0: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      cfg_q.stretch_code == 3'h0 |-> ext.setup_recovery_extension == 5'h0)
      else $error("code zero extension wrong");
   AST_X4_EN: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (!por_active && div_sel == DIV_BY_MULT && cfg.clock_multiplier_select
       && $stable(div_sel)) |-> sys_clk_en)
      else $error("x4 enable missing");
   AST_FETCH_LOW: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      state_q == ST_FETCH |-> !program_fetch_strobe_n)
      else $error("fetch strobe high in fetch");
   AST_CFG_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      bus_busy && $past(bus_busy) |-> $stable(cfg_q))
      else $error("configuration changed mid cycle");
endmodule

// ==== ebt_bus_timing_tb_top.sv ====
// Self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ps
module ebt_bus_timing_tb_top;
   import ebt_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   ebt_cfg_t cfg = '{PG_NONPAGE, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
   logic fetch_req = 1'b0;
   logic page_hit = 1'b0;
   logic data_req = 1'b0;
   logic data_write = 1'b0;
   logic sys_clk_en, reserved_div, por_active, bus_busy, cycle_done, serial_clk;
   logic addr_latch_strobe, program_fetch_strobe_n, read_strobe_n, write_strobe_n;
   logic [3:0] external_data_move_cycles;
   logic [7:0] rd_ticks, wr_ticks, ale_ticks, rec_ticks;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   int pf_rises = 0;
   int pf_low = 0;
   int pf_width = 0;
   logic pf_prev = 1'b1;

   // ------------------------------------------------------------
   // Clock, design and far-side memory
   // ------------------------------------------------------------
   // 125 MHz stands for an x4-multiplied input kept inside its band
   initial forever #4 core_clk = ~core_clk;

   ebt_bus_timing #(.POR_COUNT(16)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
      .cfg(cfg), .fetch_req(fetch_req), .page_hit(page_hit), .data_req(data_req),
      .data_write(data_write), .sys_clk_en(sys_clk_en), .reserved_div(reserved_div),
      .por_active(por_active), .bus_busy(bus_busy), .cycle_done(cycle_done),
      .external_data_move_cycles(external_data_move_cycles), .addr_latch_strobe(addr_latch_strobe),
      .program_fetch_strobe_n(program_fetch_strobe_n), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .serial_clk(serial_clk));

   ebt_ext_mem_model i_mem (.core_clk(core_clk), .sys_clk_en(sys_clk_en),
      .addr_latch_strobe(addr_latch_strobe), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .rd_ticks(rd_ticks), .wr_ticks(wr_ticks),
      .ale_ticks(ale_ticks), .rec_ticks(rec_ticks));

   // Fetch strobe rises and low width, counted mid-cycle to avoid edge races
   always @(negedge core_clk) begin
      pf_prev <= program_fetch_strobe_n;
      if (program_fetch_strobe_n === 1'b0) pf_low <= pf_low + 1;
      else pf_low <= 0;
      if (program_fetch_strobe_n === 1'b1 && pf_prev === 1'b0) begin
         pf_rises <= pf_rises + 1;
         pf_width <= pf_low;
      end
   end

   // Hang guard, well above the longest divider measurement
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches = mismatches + 1;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %0d expected %0d", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   function automatic int str_ext(input int c);
      return (c == 0) ? 0 : 4 * c - 2;
   endfunction

   // Holds the request until n completions, then drops it on the next edge
   task automatic run(input logic d, input logic w, input logic f, input int n);
      int k;
      k = 0;
      data_req <= d;
      data_write <= w;
      fetch_req <= f;
      while (n > 0 && k < 500) begin
         @(negedge core_clk);
         k++;
         if (cycle_done === 1'b1) n--;
      end
      @(posedge core_clk);
      data_req <= 1'b0;
      fetch_req <= 1'b0;
      if (k >= 500) check(32'h0, 32'h1);
   endtask

   // Cycles between sys ticks (s=0) or serial clock rises (s=1)
   task automatic per(input logic s, output int k);
      logic p, e;
      repeat (3) begin
         k = 0;
         p = serial_clk;
         do begin
            @(negedge core_clk);
            k++;
            e = s ? (serial_clk === 1'b1 && p === 1'b0) : (sys_clk_en === 1'b1);
            p = serial_clk;
         end while (!e && k < 5000);
      end
   endtask

   task automatic div_chk(input logic m, input logic [1:0] dv, input int exp);
      int k;
      @(posedge core_clk);
      cfg.clock_multiplier_select <= m;
      {cfg.clock_divider_sel_hi, cfg.clock_divider_sel_lo} <= dv;
      per(1'b0, k);
      check(k, exp);
      check(reserved_div, dv == DIV_RSVD);
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      int k, ex;
      logic bad;
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      k = 0;
      bad = 1'b0;
      while (por_active !== 1'b1 && k < 10) begin
         @(negedge core_clk);
         k++;
      end
      k = 0;
      while (por_active === 1'b1 && k < 100) begin
         @(negedge core_clk);
         k++;
         if (read_strobe_n !== 1'b1 || write_strobe_n !== 1'b1 || bus_busy !== 1'b0) bad = 1'b1;
         if (program_fetch_strobe_n !== 1'b1 || addr_latch_strobe !== 1'b0) bad = 1'b1;
      end
      check(k >= 16 && k <= 19, 1'b1);
      check(bad, 1'b0);
      $display("power-on delay test done");
      for (int pg = 0; pg < 5; pg++) begin
         for (int c = 0; c < 8; c++) begin
            @(posedge core_clk);
            cfg.page <= ebt_page_t'(pg);
            cfg.stretch_code <= c[2:0];
            repeat (2) @(posedge core_clk);
            run(1'b1, c[0], 1'b0, 1);
            repeat (3) @(negedge core_clk);
            ex = (pg < 2 ? 1 : 2) + str_ext(c);
            check(c[0] ? wr_ticks : rd_ticks, ex);
            check(external_data_move_cycles, c + 2);
            if (pg == 4) check(ale_ticks, 2 + (c > 3 ? 4 : 0));
         end
      end
      $display("strobe width test done");
      // Stretch code changed mid-cycle must wait for the next cycle
      @(posedge core_clk);
      cfg.stretch_code <= 3'h0;
      repeat (2) @(posedge core_clk);
      data_req <= 1'b1;
      data_write <= 1'b0;
      repeat (3) @(posedge core_clk);
      cfg.stretch_code <= 3'h7;
      run(1'b1, 1'b0, 1'b0, 1);
      repeat (3) @(negedge core_clk);
      check(rd_ticks, 2);
      @(posedge core_clk);
      run(1'b1, 1'b0, 1'b0, 1);
      repeat (3) @(negedge core_clk);
      check(rd_ticks, 28);
      $display("config timing test done");
      @(posedge core_clk);
      cfg.stretch_code <= 3'h4;
      repeat (2) @(posedge core_clk);
      run(1'b1, 1'b1, 1'b0, 2);
      repeat (3) @(negedge core_clk);
      check(rec_ticks >= 5, 1'b1);
      check(wr_ticks, 16);
      $display("recovery test done");
      @(posedge core_clk);
      ex = pf_rises;
      run(1'b0, 1'b0, 1'b1, 3);
      check(pf_rises - ex >= 2, 1'b1);
      check(pf_width, 2);
      cfg.page <= PG_ONE_CYC;
      page_hit <= 1'b1;
      repeat (4) @(posedge core_clk);
      ex = pf_rises;
      run(1'b0, 1'b0, 1'b1, 3);
      check(pf_rises - ex, 0);
      page_hit <= 1'b0;
      $display("page hit test done");
      div_chk(1'b1, 2'h3, 4096);
      div_chk(1'b0, 2'h2, 4);
      div_chk(1'b1, 2'h1, 1);
      div_chk(1'b0, 2'h0, 2);
      div_chk(1'b1, 2'h0, 1);
      $display("clock divider test done");
      @(posedge core_clk);
      cfg.serial_clock_rate_bit <= 1'b0;
      per(1'b1, k);
      check(k, 12);
      @(posedge core_clk);
      cfg.serial_clock_rate_bit <= 1'b1;
      per(1'b1, k);
      check(k, 4);
      $display("serial rate test done");
      end_sim();
   end
endmodule

// ==== ebt_ext_mem_model.sv ====
// Behavioural external memory that times the strobes it is given
`timescale 1ns/1ps
module ebt_ext_mem_model (
   input wire logic core_clk,
   input wire logic sys_clk_en,
   input wire logic addr_latch_strobe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   output logic [7:0] rd_ticks,
   output logic [7:0] wr_ticks,
   output logic [7:0] ale_ticks,
   output logic [7:0] rec_ticks
);
   logic [7:0] rd_c = 8'h00;
   logic [7:0] wr_c = 8'h00;
   logic [7:0] ale_c = 8'h00;
   logic [7:0] rec_c = 8'h00;
   logic rec_run = 1'b0;

   // Mid-cycle sampling so the strobes have settled after the edge
   // Counts the sys ticks for which each strobe stays active
   always @(negedge core_clk) begin
      if (sys_clk_en) begin
         if (!read_strobe_n) rd_c <= rd_c + 8'h01;
         else if (rd_c != 8'h00) begin
            rd_ticks <= rd_c;
            rd_c <= 8'h00;
         end
         if (!write_strobe_n) wr_c <= wr_c + 8'h01;
         else if (wr_c != 8'h00) begin
            wr_ticks <= wr_c;
            wr_c <= 8'h00;
         end
         if (addr_latch_strobe) ale_c <= ale_c + 8'h01;
         else if (ale_c != 8'h00) begin
            ale_ticks <= ale_c;
            ale_c <= 8'h00;
         end
         // Quiet gap from a data strobe rising to the next latch pulse
         if (!read_strobe_n || !write_strobe_n) begin
            rec_run <= 1'b1;
            rec_c <= 8'h00;
         end else if (rec_run && addr_latch_strobe) begin
            rec_ticks <= rec_c;
            rec_run <= 1'b0;
         end else if (rec_run) rec_c <= rec_c + 8'h01;
      end
   end
endmodule

// ==== ebt_pkg.sv ====
// Constants and types for the external bus cycle timing block
// Notes on behaviour
// - Clock multiplier low: x4 high, x2 low
// - Divider 10 gives 1, 11 gives 1024
// - Stretch code sets 2 to 9 cycles
// - Codes 0-3 strobe extension 0,2,6,10
// - Codes 4-7 strobe 14-26, setup five
// - Strobe low one or two plus extension
// - Latch strobe waits setup after strobe
// - Serial mode 0 rate 12 or 4
// - Power-on reset holds 65536 oscillator clocks; code counts 65536 core clocks, 16384 oscillator clocks
// - Default latch strobe 1.5 of four; code gives two of four
// - One-cycle page mode keeps fetch strobe low
package ebt_pkg;
   // ---------------------------------------------------------------
   // Encodings and counts
   // ---------------------------------------------------------------
   localparam logic [1:0] DIV_BY_MULT = 2'h0;
   localparam logic [1:0] DIV_RSVD = 2'h1;
   localparam logic [1:0] DIV_ONE = 2'h2;
   localparam logic [1:0] DIV_1024 = 2'h3;
   localparam int SLOW_DIV = 1024;
   localparam int POR_CYCLES = 65536;
   localparam int SER_SLOW = 12;
   localparam int SER_FAST = 4;
   localparam int EXTERNAL_DATA_MOVE_BASE_CYC = 2;
   localparam logic [4:0] DEF_LATCH_HI = 5'h2;
   localparam logic [4:0] DEF_CYCLE_LEN = 5'h4;

   typedef enum logic [2:0] {
      PG_ONE_CYC = 3'b000,
      PG_TWO_CYC = 3'b001,
      PG_FOUR_CYC = 3'b010,
      PG_MODE2 = 3'b011,
      PG_NONPAGE = 3'b100
   } ebt_page_t;

   typedef struct packed {
      ebt_page_t page;
      logic [2:0] stretch_code;
      logic clock_multiplier_select;
      logic clock_divider_sel_hi;
      logic clock_divider_sel_lo;
      logic serial_clock_rate_bit;
      logic serial_mode_bit_a;
      logic serial_mode_bit_b;
   } ebt_cfg_t;

   typedef struct packed {
      logic [4:0] strobe_extension;
      logic [4:0] setup_recovery_extension;
      logic [4:0] latch_pulse_extension;
      logic [4:0] address_hold_extension;
      logic [4:0] address_valid_extension;
   } ebt_ext_t;
endpackage

// ==== ebt_stretch_decode.sv ====
// Stretch code to phase extension decoder
`timescale 1ns/1ps
module ebt_stretch_decode (
   input wire logic [2:0] code,
   output ebt_pkg::ebt_ext_t ext
);
   import ebt_pkg::*;
   // ---------------------------------------------------------------
   // Extension table
   // ---------------------------------------------------------------
   // Strobe grows 4 per code past code 1
   always_comb begin
      ext.strobe_extension = (code == 3'h0) ? 5'h0 : 5'(4 * int'(code) - 2);
      ext.setup_recovery_extension = code[2] ? 5'h5 : ((code == 3'h0) ? 5'h0 : 5'h1);
      ext.latch_pulse_extension = code[2] ? 5'h4 : 5'h0;
      ext.address_hold_extension = code[2] ? 5'h1 : 5'h0;
      ext.address_valid_extension = (code == 3'h0) ? 5'h0 : 5'h1;
   end
endmodule
